// file: logic/flash_program_strobe_host.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Writes need high voltage; selects pick write, lock bits, erase.
// - Readback uses logic-high reset, strobe high, selects LLHH.
// - Host pulses strobe once; device self-times the write.
// - Host presents data before raising high voltage.
// - Host lowers voltage to logic high and selects read before sampling.
// - Host waits until polled data reads true before next cycle; code gives up with an error after wc_timeout plus setup_cycles.
// - Erase holds strobe low ten milliseconds; array and locks cleared.
// - Power up with reset and clock pin low, then raise both highs.
// - Next byte: pulse clock pin once and present new data.
// - Full readback: clear counter by reset rise, alternate read and clock.
// - Power off: clock pin low, then reset low, then supply off.
module flash_program_strobe_host
	import program_strobe_pkg::*;
#(
	parameter int setup_cycles = program_strobe_pkg::setup_cyc,
	parameter int erase_cycles = program_strobe_pkg::erase_cyc,
	parameter int wc_timeout   = program_strobe_pkg::wc_max_cyc
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             power_on,
	output logic             reset_hv_pin,
	output logic             reset_high_pin,
	output logic             clock_input_pin,
	output logic             strobe_pin,
	output logic             sel_a,
	output logic             sel_b,
	output logic             sel_c,
	output logic             sel_d,
	input  wire logic [7:0]  data_in,
	output logic      [7:0]  data_out,
	output logic             data_oe,
	input  wire logic        busy_pin
);
	import program_strobe_pkg::*;

	// One clock and one reset for every check in this module.
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	// ---------------------------------------------------------------
	// States
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		st_idle, st_setup, st_hv, st_pulse, st_wait, st_lower,
		st_rsample, st_clk_hi, st_clk_lo, st_poff
	} state_type;

	state_type        state_r;
	logic [cnt_w-1:0] cnt_r;
	cmd_type          cmd_r;
	logic [7:0]       wdata_r;
	logic [10:0]      addr_r;
	logic             err_r;
	logic             go;
	logic [7:0]       din_s1_r, din_s2_r;
	logic             busy_s1_r, busy_s2_r;
	logic             sample;
	logic [7:0]       rdata;
	logic             advance_r;

	// Terminal-count test shared by all timed steps.
	function automatic logic done_at(input logic [cnt_w-1:0] c,
	                                 input int n);
		return c >= n[cnt_w-1:0];
	endfunction

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	// Pins from the device cross into clk_sys through two stages.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			din_s1_r  <= 8'h00;
			din_s2_r  <= 8'h00;
			busy_s1_r <= 1'b1;
			busy_s2_r <= 1'b1;
		end else begin
			din_s1_r  <= data_in;
			din_s2_r  <= din_s1_r;
			busy_s1_r <= busy_pin;
			busy_s2_r <= busy_s1_r;
		end
	end

	// ---------------------------------------------------------------
	// APB slave
	// ---------------------------------------------------------------
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign go = psel && penable && pwrite && paddr == ctrl_off &&
	            pwdata[go_bit] && state_r == st_idle;

	// Command and data registers; only accepted while idle.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cmd_r   <= cmd_power_up;
			wdata_r <= 8'h00;
		end else begin
			if (go) begin
				cmd_r <= cmd_type'(pwdata[cmd_lsb +: cmd_w]);
			end
			if (psel && penable && pwrite && paddr == wdata_off &&
			    state_r == st_idle) begin
				wdata_r <= pwdata[7:0];
			end
		end
	end

	// Read mux; unmapped addresses read zero.
	always_comb begin
		prdata = 32'h0000_0000;
		if (paddr == status_off) begin
			prdata[busy_bit]    = state_r != st_idle;
			prdata[err_bit]     = err_r;
			prdata[powered_bit] = power_on;
		end else if (paddr == rdata_off) begin
			prdata[7:0] = rdata;
		end else if (paddr == wdata_off) begin
			prdata[7:0] = wdata_r;
		end else if (paddr == addr_off) begin
			prdata[10:0] = addr_r;
		end else if (paddr == ctrl_off) begin
			prdata[cmd_lsb +: cmd_w] = cmd_r;
		end
	end

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	// One step per state; steps last setup_cycles, except the strobe pulse (pulse_cyc or erase_cycles) and the wait and poll steps, which can run longer.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= st_idle;
			cnt_r   <= '0;
			err_r   <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			case (state_r)
				st_idle: begin
					cnt_r <= '0;
					if (go) begin
						err_r   <= 1'b0;
						state_r <= st_setup;
					end
				end
				st_setup: if (done_at(cnt_r, setup_cycles)) begin
					cnt_r <= '0;
					if (cmd_r == cmd_power_off) begin
						state_r <= st_poff;
					end else if (cmd_r == cmd_power_up) begin
						state_r <= st_idle;
					end else if (cmd_r == cmd_read || cmd_r == cmd_sig) begin
						state_r <= st_rsample;
					end else begin
						state_r <= st_hv;
					end
				end
				st_hv: if (done_at(cnt_r, setup_cycles)) begin
					cnt_r   <= '0;
					state_r <= st_pulse;
				end
				st_pulse: if (done_at(cnt_r, cmd_r == cmd_erase ?
				                      erase_cycles : pulse_cyc)) begin
					cnt_r   <= '0;
					state_r <= st_wait;
				end
				// Wait for busy to clear, or give up with an error after wc_timeout plus setup_cycles.
				st_wait: begin
					if (done_at(cnt_r, setup_cycles) && busy_s2_r) begin
						cnt_r   <= '0;
						state_r <= st_lower;
					end else if (done_at(cnt_r, wc_timeout + setup_cycles)) begin
						err_r   <= 1'b1;
						cnt_r   <= '0;
						state_r <= st_lower;
					end
				end
				st_lower: if (done_at(cnt_r, setup_cycles)) begin
					cnt_r   <= '0;
					state_r <= (cmd_r == cmd_write) ? st_rsample : st_idle;
				end
				st_rsample: if (done_at(cnt_r, setup_cycles)) begin
					// Polling is bounded, so a refused byte cannot hang us.
					if (cmd_r == cmd_write && din_s2_r[7] != wdata_r[7] &&
					    !done_at(cnt_r, wc_timeout + setup_cycles)) begin
						state_r <= st_rsample;
					end else begin
						cnt_r   <= '0;
						state_r <= st_clk_hi;
						if (cmd_r == cmd_write && din_s2_r != wdata_r) begin
							err_r <= 1'b1;
						end
					end
				end
				st_clk_hi: if (done_at(cnt_r, setup_cycles)) begin
					cnt_r   <= '0;
					state_r <= st_clk_lo;
				end
				st_clk_lo: if (done_at(cnt_r, setup_cycles)) begin
					cnt_r   <= '0;
					state_r <= st_idle;
				end
				st_poff: if (done_at(cnt_r, setup_cycles)) begin
					cnt_r   <= '0;
					state_r <= st_idle;
				end
				default: state_r <= st_idle;
			endcase
		end
	end

	assign sample = state_r == st_rsample && done_at(cnt_r, setup_cycles);

	// Captured readback byte lives in the little holding register.
	word_reg u_rdata (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.load    (sample),
		.din     (din_s2_r),
		.dout    (rdata)
	);

	// ---------------------------------------------------------------
	// Pin drivers
	// ---------------------------------------------------------------
	// Supply and reset levels; power off drops clock, then reset, then
	// supply, each step a full setup time apart.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			power_on       <= 1'b0;
			reset_high_pin <= 1'b0;
			reset_hv_pin   <= 1'b0;
		end else begin
			if (state_r == st_setup && cmd_r == cmd_power_up) begin
				power_on <= 1'b1;
				if (done_at(cnt_r, setup_cycles)) begin
					reset_high_pin <= 1'b1;
				end
			end
			// High voltage rises halfway through its step, after data settled.
			if (state_r == st_hv && done_at(cnt_r, setup_cycles / 2)) begin
				reset_hv_pin <= 1'b1;
			end
			if (state_r == st_lower) begin
				reset_hv_pin <= 1'b0;
			end
			if (state_r == st_poff) begin
				reset_high_pin <= 1'b0;
				if (done_at(cnt_r, setup_cycles)) begin
					power_on <= 1'b0;
				end
			end
		end
	end

	// Strobe low only for the program or erase pulse.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			strobe_pin <= 1'b1;
		end else begin
			strobe_pin <= state_r != st_pulse;
		end
	end

	// Clock pin pulse advances the device counter after each byte.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			clock_input_pin <= 1'b0;
			advance_r       <= 1'b0;
			addr_r          <= '0;
		end else begin
			clock_input_pin <= state_r == st_clk_hi;
			advance_r       <= state_r == st_clk_hi;
			if (state_r == st_clk_hi && !advance_r) begin
				addr_r <= addr_r + 11'd1;
			end
			if (state_r == st_poff || (state_r == st_setup &&
			    cmd_r == cmd_power_up)) begin
				addr_r <= '0;
			end
		end
	end

	// Select lines and data port follow the command.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			{sel_d, sel_c, sel_b, sel_a} <= 4'hF;
			data_out <= 8'h00;
			data_oe  <= 1'b0;
		end else if (state_r == st_setup) begin
			case (cmd_r)
				cmd_write: {sel_d, sel_c, sel_b, sel_a} <= sel_write;
				cmd_read:  {sel_d, sel_c, sel_b, sel_a} <= sel_read;
				cmd_sig:   {sel_d, sel_c, sel_b, sel_a} <= sel_sig;
				cmd_lock1: {sel_d, sel_c, sel_b, sel_a} <= sel_lock1;
				cmd_lock2: {sel_d, sel_c, sel_b, sel_a} <= sel_lock2;
				cmd_erase: {sel_d, sel_c, sel_b, sel_a} <= sel_erase;
				default:   {sel_d, sel_c, sel_b, sel_a} <= 4'hF;
			endcase
			data_out <= wdata_r;
			data_oe  <= cmd_r == cmd_write;
		end else if (state_r == st_lower) begin
			{sel_d, sel_c, sel_b, sel_a} <= sel_read;
			data_oe <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_hv_after_data: assert property (
		$rose(reset_hv_pin) && cmd_r == cmd_write |-> data_oe)
		else $error("high voltage raised without data");
	a_strobe_only_hv: assert property (
		!strobe_pin |-> reset_hv_pin)
		else $error("strobe low without high voltage");
	a_read_no_drive: assert property (
		state_r == st_rsample |-> !data_oe && !reset_hv_pin)
		else $error("sampling while driving or at high voltage");
	a_clk_off_first: assert property (
		$fell(reset_high_pin) |-> !clock_input_pin)
		else $error("reset dropped with clock pin high");
	a_power_before: assert property (
		$rose(reset_high_pin) |-> power_on && !clock_input_pin)
		else $error("reset raised without power");
	a_pulse_once: assert property (
		$rose(strobe_pin) |=> strobe_pin [*2])
		else $error("strobe pulsed twice");
	a_clk_follows: assert property (
		$rose(clock_input_pin) |-> $past(state_r) == st_clk_hi)
		else $error("clock pulse outside advance step");
	a_wait_busy: assert property (
		state_r == st_wait ##1 state_r == st_lower |-> busy_s2_r || err_r)
		else $error("left wait while busy");
	c_write: cover property (@(posedge clk_sys) cmd_r == cmd_write &&
		state_r == st_clk_lo);
	c_erase: cover property (@(posedge clk_sys) cmd_r == cmd_erase &&
		state_r == st_wait);
	c_sig: cover property (@(posedge clk_sys) sample && cmd_r == cmd_sig);
endmodule // flash_program_strobe_host

// file: logic/program_strobe_pkg.sv
package program_strobe_pkg;

	// ---------------------------------------------------------------
	// Register map of the controller (byte addresses on APB)
	// ---------------------------------------------------------------
	localparam logic [7:0] ctrl_off      = 8'h00;
	localparam logic [7:0] wdata_off     = 8'h04;
	localparam logic [7:0] status_off    = 8'h08;
	localparam logic [7:0] rdata_off     = 8'h0C;
	localparam logic [7:0] addr_off      = 8'h10;

	// ---------------------------------------------------------------
	// Control register fields
	// ---------------------------------------------------------------
	localparam int cmd_lsb = 0;
	localparam int cmd_w   = 3;
	localparam int go_bit  = 4;

	// ---------------------------------------------------------------
	// Status register fields
	// ---------------------------------------------------------------
	localparam int busy_bit    = 0;
	localparam int err_bit     = 1;
	localparam int powered_bit = 2;

	// ---------------------------------------------------------------
	// Commands
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		cmd_power_up,
		cmd_write,
		cmd_read,
		cmd_sig,
		cmd_lock1,
		cmd_lock2,
		cmd_erase,
		cmd_power_off
	} cmd_type;

	// ---------------------------------------------------------------
	// Select line codes {sel_d, sel_c, sel_b, sel_a}
	// ---------------------------------------------------------------
	localparam logic [3:0] sel_write = 4'hE;
	localparam logic [3:0] sel_read  = 4'hC;
	localparam logic [3:0] sel_lock1 = 4'hF;
	localparam logic [3:0] sel_lock2 = 4'h3;
	localparam logic [3:0] sel_erase = 4'h1;
	localparam logic [3:0] sel_sig   = 4'h0;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int clk_mhz      = 200;
	localparam int setup_us     = 10;
	localparam int setup_cyc    = setup_us * clk_mhz;
	localparam int pulse_us     = 2;
	localparam int pulse_cyc    = pulse_us * clk_mhz;
	localparam int erase_ms     = 10;
	localparam int erase_cyc    = erase_ms * 1000 * clk_mhz;
	localparam int wc_max_ms    = 2;
	localparam int wc_max_cyc   = wc_max_ms * 1000 * clk_mhz;
	localparam int cnt_w        = 22;
	localparam int rdata_rst    = 0;

endpackage

// file: logic/word_reg.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Small holding register for data captured from the device.
// ---------------------------------------------------------------
module word_reg (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       load,
	input  wire logic [7:0] din,
	output logic      [7:0] dout
);
	// Captured byte is held until the next load.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dout <= 8'h00;
		end else if (load) begin
			dout <= din;
		end
	end
endmodule // word_reg

// file: tb/dev_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Behavioural flash device at the far side of the controller.
// ---------------------------------------------------------------
module dev_model
	import program_strobe_pkg::*;
#(
	parameter int          wc_cyc    = 60,
	parameter int          erase_low = 48,
	parameter logic [23:0] sig_bytes = 24'h000000
) (
	input  wire logic       clk_sys,
	input  wire logic       reset_high_pin,
	input  wire logic       reset_hv_pin,
	input  wire logic       clock_input_pin,
	input  wire logic       strobe_pin,
	input  wire logic [3:0] sel,
	input  wire logic [7:0] bus,
	input  wire logic       data_oe,
	output logic      [7:0] dev_data,
	output logic            dev_oe,
	output logic            busy_pin,
	output logic            viol
);
	logic [7:0]  mem [2048];
	logic [10:0] cnt, last_a;
	logic        lk1, lk2, rh_q, ck_q, st_q, hv_q;
	logic [7:0]  rd;
	int          busy_n, low_n;

	// Shipped erased and unlocked.
	initial begin
		foreach (mem[i]) mem[i] = 8'hFF;
		{lk1, lk2, rh_q, ck_q, hv_q, viol, cnt, last_a} = '0;
		st_q = 1'b1;
		busy_n = 0;
		low_n = 0;
	end

	// Pin edges are found by sampling, so slow strobes are safe.
	always @(posedge clk_sys) begin
		rh_q <= reset_high_pin;
		ck_q <= clock_input_pin;
		st_q <= strobe_pin;
		hv_q <= reset_hv_pin;
		low_n <= strobe_pin ? 0 : low_n + 1;
		if (busy_n > 0) busy_n <= busy_n - 1;
		if (reset_high_pin && !rh_q) cnt <= '0;
		else if (clock_input_pin && !ck_q) cnt <= cnt + 1;
		if (reset_high_pin && !rh_q && clock_input_pin) viol <= 1'b1;
		if (reset_hv_pin && !hv_q && sel == sel_write && !data_oe)
			viol <= 1'b1;
		if (!strobe_pin && st_q && busy_n > 0) viol <= 1'b1;
		if (reset_hv_pin && strobe_pin && !st_q) begin
			if (sel == sel_erase && low_n >= erase_low) begin
				foreach (mem[i]) mem[i] <= 8'hFF;
				lk1 <= 1'b0;
				lk2 <= 1'b0;
			end else if (sel != sel_erase) begin
				busy_n <= wc_cyc;
				last_a <= cnt;
				if (sel == sel_lock1) lk1 <= 1'b1;
				if (sel == sel_lock2) lk2 <= 1'b1;
				if (sel == sel_write && !lk1 && mem[cnt] == 8'hFF)
					mem[cnt] <= bus;
			end
		end
	end

	// Lock state shows only through blocked accesses.
	always_comb begin
		rd = (sel == sel_sig) ? (cnt < 3 ? sig_bytes[8*cnt +: 8] : 8'hFF)
			: mem[cnt];
		if (lk1 && lk2 && sel == sel_read) rd = 8'hFF;
		if (busy_n > 0 && cnt == last_a) rd[7] = ~mem[cnt][7];
		dev_data = rd;
		dev_oe = reset_high_pin && !reset_hv_pin && strobe_pin
			&& (sel == sel_read || sel == sel_sig);
		busy_pin = (busy_n == 0);
	end
endmodule // dev_model

// file: tb/tb_top.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Bench for the flash programming controller.
// ---------------------------------------------------------------
module tb_top;
	import program_strobe_pkg::*;
	localparam logic [23:0] sig_v   = 24'h775CA5; // Arbitrary values.
	localparam int          erase_n = 50;
	logic        clk_sys = 1'b0;
	logic        rst_n   = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata, rv;
	logic        pready, pslverr, se, power_on, reset_hv_pin;
	logic        reset_high_pin, clock_input_pin, strobe_pin;
	logic        sel_a, sel_b, sel_c, sel_d, data_oe, dev_oe;
	logic        busy_pin, viol;
	logic [7:0]  data_out, dev_data;
	wire  [7:0]  bus;
	int          mismatches, n_tests, m_addr, m_mem [2048];
	bit          m_lk1, m_lk2;

	always #2.5 clk_sys = ~clk_sys;
	// Pull-ups hold released data lines high.
	assign bus = data_oe ? data_out : (dev_oe ? dev_data : 8'hFF);

	// Short step and pulse counts keep the run brief.
	flash_program_strobe_host #(.erase_cycles(erase_n), .wc_timeout(100),
		.setup_cycles(40))
	u_flash_program_strobe_host (.clk_sys, .rst_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .power_on,
		.reset_hv_pin, .reset_high_pin, .clock_input_pin, .strobe_pin,
		.sel_a, .sel_b, .sel_c, .sel_d, .data_in(bus), .data_out,
		.data_oe, .busy_pin);
	dev_model #(.wc_cyc(60), .erase_low(erase_n - 2), .sig_bytes(sig_v))
	u_dev_model (.clk_sys, .reset_high_pin, .reset_hv_pin,
		.clock_input_pin, .strobe_pin, .sel({sel_d, sel_c, sel_b, sel_a}),
		.bus, .data_oe, .dev_data, .dev_oe, .busy_pin, .viol);

	task automatic check(string what, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (e !== g) begin
			mismatches++;
			$display("[ERR] %s expected %0h seen %0h", what, e, g);
		end
	endtask

	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// One APB transfer; read data is taken at the ready edge.
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rv = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			mismatches++;
			stop_test();
		end
		@(posedge clk_sys);
	endtask

	// Issue a command and wait for the sequencer to go idle.
	task automatic run(cmd_type c, logic [7:0] d, bit dbl);
		int k;
		apb(1'b1, wdata_off, {24'h0, d});
		apb(1'b1, ctrl_off, (32'd1 << go_bit) | 32'(c));
		if (dbl) apb(1'b1, ctrl_off, (32'd1 << go_bit) | 32'(cmd_read));
		k = 0;
		do begin
			apb(1'b0, status_off, 32'h0);
			k++;
		end while (rv[busy_bit] !== 1'b0 && k < 2000);
		if (k >= 2000) begin
			mismatches++;
			stop_test();
		end
	endtask

	task automatic wr_byte(logic [7:0] d, bit dbl);
		bit bad;
		run(cmd_write, d, dbl);
		if (!m_lk1 && m_mem[m_addr] == 255) m_mem[m_addr] = d;
		bad = m_mem[m_addr] != d;
		check("verify flag", bad, rv[err_bit]);
		m_addr++;
	endtask

	task automatic rd_byte(cmd_type c);
		logic [7:0] e;
		run(c, 8'h00, 1'b0);
		apb(1'b0, rdata_off, 32'h0);
		e = (m_lk1 && m_lk2) ? 8'hFF : 8'(m_mem[m_addr]);
		if (c == cmd_sig) e = 8'(sig_v >> (8 * m_addr));
		check("read byte", e, rv[7:0]);
		m_addr++;
	endtask

	task automatic cycle();
		run(cmd_power_off, 8'h00, 1'b0);
		check("pins off", {power_on, reset_hv_pin, reset_high_pin,
			clock_input_pin}, 4'h0);
		run(cmd_power_up, 8'h00, 1'b0);
		check("powered", 1'b1, rv[powered_bit]);
		m_addr = 0;
	endtask

	// Main sequence; the counter restarts on every power cycle.
	initial begin
		foreach (m_mem[i]) m_mem[i] = 255;
		void'($urandom(16));
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		check("reset pins", {power_on, strobe_pin, data_oe}, 3'b010);
		cycle();
		for (int i = 0; i < 4; i++) wr_byte(8'($urandom % 255), 1'b0);
		$display("Test program done");
		cycle();
		for (int i = 0; i < 4; i++) rd_byte(cmd_read);
		apb(1'b0, addr_off, 32'h0);
		check("address", m_addr, rv[10:0]);
		apb(1'b0, 8'h14, 32'h0);
		check("unmapped slverr", 1'b0, se);
		check("unmapped data", 32'h0, rv);
		cycle();
		for (int i = 0; i < 3; i++) rd_byte(cmd_sig);
		$display("Test readback done");
		cycle();
		wr_byte(8'h00, 1'b0);
		wr_byte(8'h5A, 1'b1);
		apb(1'b0, addr_off, 32'h0);
		check("address", m_addr, rv[10:0]);
		$display("Test rewrite done");
		run(cmd_lock1, 8'h00, 1'b0);
		m_lk1 = 1'b1;
		cycle();
		for (int i = 0; i < 4; i++) rd_byte(cmd_read);
		wr_byte(8'h3C, 1'b0);
		run(cmd_lock2, 8'h00, 1'b0);
		m_lk2 = 1'b1;
		cycle();
		rd_byte(cmd_read);
		$display("Test lock done");
		run(cmd_erase, 8'h00, 1'b0);
		foreach (m_mem[i]) m_mem[i] = 255;
		{m_lk1, m_lk2} = 2'b00;
		cycle();
		rd_byte(cmd_read);
		wr_byte(8'(($urandom % 254) + 1), 1'b0);
		cycle();
		rd_byte(cmd_read);
		rd_byte(cmd_read);
		run(cmd_power_off, 8'h00, 1'b0);
		check("pins off", {power_on, reset_hv_pin, reset_high_pin,
			clock_input_pin}, 4'h0);
		check("pin order", 1'b0, viol);
		$display("Test erase done");
		stop_test();
	end
endmodule // tb_top
